// file: bench/cpu_side.sv
// Purpose: Processor-side request source for the segment/page translator.
// Assumes: One request per call, launched just after a rising edge.
// Notes: Idle cycles drop the strobe and invert the address and write data so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module cpu_side (
  // Clock.
  input wire logic clock,
  // Request to the translator.
  output logic req,
  output logic [23:0] addr,
  output logic write,
  output logic sup,
  output logic fetch,
  output logic [15:0] wdata
);
  initial begin
    req = 1'b0;
    addr = 24'h000000;
    {write, sup, fetch} = 3'h0;
    wdata = 16'h0000;
  end

  // Calls may follow each other directly, giving one request per cycle.
  task automatic access(input logic [23:0] a, input logic [2:0] wsf, input logic [15:0] d);
    @(posedge clock);
    req <= 1'b1;
    addr <= a;
    {write, sup, fetch} <= wsf;
    wdata <= d;
  endtask

  task automatic idle();
    @(posedge clock);
    req <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
endmodule // cpu_side
`default_nettype wire

// file: bench/test_segment_page_mmu.sv
// Purpose: Self-checking bench for the segment/page translator.
// Assumes: Answers come one clock after each request.
// Notes: PPN_BITS is cut to 10 so that ignored page number bits are exercised.
`timescale 1ns/1ps
`default_nettype none
module test_segment_page_mmu;
  import segment_page_mmu_pkg::*;
  localparam int PB = 10;
  typedef struct packed {
    logic berr;
    logic [15:0] rdata;
    logic go;
    logic [22:0] maddr;
    logic [1:0] space;
  } note_t;
  // Supervisor rwx in bits 5:3, user rwx in bits 2:0.
  localparam logic [5:0] rights_tab [16] = '{6'h00, 6'h08, 6'h20, 6'h28, 6'h30, 6'h38, 6'h24, 6'h34,
    6'h26, 6'h36, 6'h35, 6'h37, 6'h2D, 6'h3D, 6'h39, 6'h3F};
  logic clock, rst_b, req, write, sup, fetch, done, berr, go, req_d;
  logic [23:0] addr;
  logic [15:0] wdata, rdata;
  logic [22:0] maddr;
  page_type_t space;
  int n_fail = 0;
  int n_compared = 0;
  note_t notes[$];
  note_t got;
  logic [9:0] seg_tab [1024];
  logic [15:0] pte [1024];
  logic [3:0] ctx = 4'h0;

  cpu_side u_cpu (.clock(clock), .req(req), .addr(addr), .write(write), .sup(sup), .fetch(fetch),
    .wdata(wdata));
  segment_page_mmu #(.PPN_BITS(PB)) DUT (.clock(clock), .rst_b(rst_b), .cpu_req(req), .cpu_addr(addr),
    .cpu_write(write), .cpu_super(sup), .cpu_fetch(fetch), .cpu_wdata(wdata), .cpu_done(done),
    .cpu_berr(berr), .cpu_rdata(rdata), .mem_go(go), .mem_addr(maddr), .mem_space(space));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Works out the answer and map side effects, notes them, then issues the request.
  task automatic op(input logic [23:0] a, input logic [2:0] wsf, input logic [15:0] d);
    note_t n;
    logic [9:0] si;
    logic [9:0] pi;
    logic [2:0] need;
    logic [5:0] r;
    n = '0;
    si = {ctx, a[20:15]};
    pi = {seg_tab[si][5:0], a[14:11]};
    need = wsf[2] ? 3'h2 : (wsf[0] ? 3'h1 : 3'h4);
    r = rights_tab[seg_tab[si][9:6]];
    if (!wsf[1] && a >= 24'h200000) n.berr = 1'b1;
    else case (a[23:21])
      3'h0: begin
        if (((wsf[1] ? r[5:3] : r[2:0]) & need) == 3'h0) n.berr = 1'b1;
        else if (pte[pi][13:12] == 2'h1) n.berr = 1'b1;
        else begin
          n.go = 1'b1;
          n.maddr = {pte[pi][11:0] & ((12'h1 << PB) - 12'h1), a[10:0]};
          n.space = pte[pi][13:12];
          pte[pi][15] = 1'b1;
          pte[pi][14] |= wsf[2];
        end
      end
      3'h5: if (wsf[2]) pte[pi] = d; else n.rdata = pte[pi];
      3'h6: if (wsf[2]) seg_tab[si] = {d[11:8], d[5:0]};
        else n.rdata = {ctx, seg_tab[si][9:6], 2'h0, seg_tab[si][5:0]};
      3'h7: if (wsf[2]) ctx = d[15:12];
      default: ;
    endcase
    notes.push_back(n);
    u_cpu.access(a, wsf, d);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (rst_b === 1'b1) check(done, req_d, "answer timing");
    req_d = (rst_b === 1'b1) && (req === 1'b1);
    if (done === 1'b1) begin
      if (notes.size() == 0) check(1, 0, "unexpected answer");
      else begin
        got = notes.pop_front();
        check(berr, got.berr, "bus error");
        check(rdata, got.rdata, "read data");
        check(go, got.go, "memory start");
        if (got.go) check({maddr, space}, {got.maddr, got.space}, "physical address");
      end
    end
  end

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [1:0] t;
    rst_b = 1'b0;
    void'($urandom(32'h80D2));
    repeat (16) @(posedge clock);
    check({done, berr, go, rdata}, 0, "reset outputs");
    rst_b <= 1'b1;
    op(24'hE00000, 3'h6, 16'h3000 | (16'($urandom) & 16'h0FFF));
    for (int i = 0; i < 16; i++) begin
      // Segment entries go in before their page entries.
      op(24'hC00000 | 24'(i) << 15, 3'h6, {4'h0, 4'(i), 2'h0, 6'(i)});
      op(24'hC00000 | 24'(i) << 15, 3'h2, 16'h0000);
      t = 2'($urandom % 3);
      op(24'hA00000 | 24'(i) << 15, 3'h6, {2'h0, t == 2'h0 ? 2'h0 : t + 2'h1, 12'($urandom)});
      op(24'hA00800 | 24'(i) << 15, 3'h6, {4'h1, 12'($urandom)});
      for (int m = 0; m < 8; m++) op(24'(i) << 15 | (24'($urandom) & 24'h7FF), 3'(m), 16'($urandom));
      op(24'h000800 | 24'(i) << 15, 3'h2, 16'h0000);
      op(24'hA00000 | 24'(i) << 15, 3'h2, 16'h0000);
      op(24'hA00800 | 24'(i) << 15, 3'h2, 16'h0000);
    end
    op(24'h400000, 3'h0, 16'h0000);
    op(24'h400000, 3'h2, 16'h0000);
    op(24'hE00000, 3'h2, 16'h0000);
    // The bench executes no code from mapped space, so switching context here is safe.
    op(24'hE00000, 3'h6, 16'h5ABC);
    op(24'hC00000, 3'h6, 16'h0F07);
    op(24'hC00000, 3'h2, 16'h0000);
    op(24'h000123, 3'h0, 16'h0000);
    op(24'hE00000, 3'h6, 16'h3000);
    op(24'hC00000, 3'h2, 16'h0000);
    u_cpu.idle();
    repeat (4) @(posedge clock);
    check(notes.size(), 0, "answers missing");
    // A second reset mid-run must bring the context back to zero.
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    check({done, berr, go, rdata}, 0, "outputs in second reset");
    rst_b <= 1'b1;
    ctx = 4'h0;
    op(24'hC00000, 3'h6, 16'h0A15);
    op(24'hC00000, 3'h2, 16'h0000);
    u_cpu.idle();
    repeat (4) @(posedge clock);
    check(notes.size(), 0, "answers missing after reset");
    tally_and_finish();
  end
endmodule // test_segment_page_mmu
`default_nettype wire

// file: inc/segment_page_mmu_pkg.sv
// Purpose: Types shared by the segment/page translator.
// Assumes: Constants come from segment_page_mmu_regs.svh.
// Notes: state_t holds every flip-flop of the top module except the map arrays.
`include "segment_page_mmu_regs.svh"
package segment_page_mmu_pkg;
  typedef enum logic [1:0] {
    PG_ONBOARD = 2'h0,
    PG_NONE = 2'h1,
    PG_BUSMEM = 2'h2,
    PG_BUSIO = 2'h3
  } page_type_t;

  typedef struct packed {
    logic [3:0] ctx;
    logic done;
    logic berr;
    logic [15:0] rdata;
    logic go;
    logic [22:0] maddr;
    page_type_t space;
  } state_t;
endpackage

// file: inc/segment_page_mmu_regs.svh
// Purpose: Offsets, field positions, reset values and sizes of the segment/page translator.
// Assumes: 24-bit processor byte addresses, 16-bit map entries.
// Notes: Register windows are decoded on address bits 23:21 only.
`ifndef SEGMENT_PAGE_MMU_REGS_SVH
`define SEGMENT_PAGE_MMU_REGS_SVH
// Register window base addresses and their decode field.
`define MMU_PAGE_TABLE_OFS 24'hA00000
`define MMU_SEG_TABLE_OFS 24'hC00000
`define MMU_CTX_SELECT_OFS 24'hE00000
`define MMU_WIN_HI 23
`define MMU_WIN_LO 21
`define MMU_MAPPED_WIN 3'h0
`define MMU_SYS_LIMIT 24'h200000
// Virtual address fields.
`define VA_SEG_HI 20
`define VA_SEG_LO 15
`define VA_PAGE_HI 14
`define VA_PAGE_LO 11
`define VA_BYTE_HI 10
// Segment entry fields.
`define STE_CTX_HI 15
`define STE_CTX_LO 12
`define STE_PROT_HI 11
`define STE_PROT_LO 8
`define STE_PTR_HI 5
`define STE_PTR_LO 0
// Page entry fields.
`define PTE_ACCESSED 15
`define PTE_MODIFIED 14
`define PTE_TYPE_HI 13
`define PTE_TYPE_LO 12
`define PTE_PPN_HI 11
`define PTE_PPN_LO 0
// Context selector field in the written data word.
`define CTX_DATA_HI 15
`define CTX_DATA_LO 12
`define CTX_RESET 4'h0
// Table sizes.
`define SEG_ENTRIES 1024
`define PAGE_ENTRIES 1024
`define PPN_WIDTH 12
`endif

// file: logic/segment_page_mmu.sv
// Purpose: Two-level segment/page address translator with protection and page statistics.
// Assumes: Requests come from logic on the same clock; one request per cycle at most.
// Notes: Answers appear one clock after the request; map arrays hold no reset value.
`timescale 1ns/1ps
`default_nettype none
`include "segment_page_mmu_regs.svh"
module segment_page_mmu #(
  parameter int PPN_BITS = `PPN_WIDTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Processor request.
  input wire logic cpu_req,
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_super,
  input wire logic cpu_fetch,
  input wire logic [15:0] cpu_wdata,
  // Processor answer.
  output logic cpu_done,
  output logic cpu_berr,
  output logic [15:0] cpu_rdata,
  // Translated memory access.
  output logic mem_go,
  output logic [22:0] mem_addr,
  output segment_page_mmu_pkg::page_type_t mem_space
);
  import segment_page_mmu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks and constants.

  if (PPN_BITS < 1 || PPN_BITS > `PPN_WIDTH) begin : g_bad_ppn_bits
    $error("PPN_BITS must lie between 1 and 12");
  end

  localparam logic [11:0] PPN_MASK = 12'(~(12'hFFF << PPN_BITS));
  localparam logic [2:0] WIN_PAGE = 3'(`MMU_PAGE_TABLE_OFS >> `MMU_WIN_LO);
  localparam logic [2:0] WIN_SEG = 3'(`MMU_SEG_TABLE_OFS >> `MMU_WIN_LO);
  localparam logic [2:0] WIN_CTX = 3'(`MMU_CTX_SELECT_OFS >> `MMU_WIN_LO);

  // Rights as {sup r, w, x, user r, w, x}.
  function automatic logic [5:0] prot_rights(input logic [3:0] code);
    case (code)
      4'h0: prot_rights = 6'h00;
      4'h1: prot_rights = 6'h08;
      4'h2: prot_rights = 6'h20;
      4'h3: prot_rights = 6'h28;
      4'h4: prot_rights = 6'h30;
      4'h5: prot_rights = 6'h38;
      4'h6: prot_rights = 6'h24;
      4'h7: prot_rights = 6'h34;
      4'h8: prot_rights = 6'h26;
      4'h9: prot_rights = 6'h36;
      4'hA: prot_rights = 6'h35;
      4'hB: prot_rights = 6'h37;
      4'hC: prot_rights = 6'h2D;
      4'hD: prot_rights = 6'h3D;
      4'hE: prot_rights = 6'h39;
      4'hF: prot_rights = 6'h3F;
      default: prot_rights = 6'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Map arrays and lookup.

  state_t state_reg;
  state_t state_next;
  logic [9:0] seg_mem [0:`SEG_ENTRIES-1];
  logic [15:0] page_mem [0:`PAGE_ENTRIES-1];
  logic [9:0] seg_idx;
  logic [9:0] pg_idx;
  logic [9:0] ste;
  logic [15:0] pte;
  logic [3:0] ste_prot;
  logic [5:0] ste_ptr;
  logic [5:0] rights;
  logic [2:0] lvl_rights;
  logic allowed;
  logic user_fault;
  logic seg_we;
  logic [9:0] seg_wdata;
  logic pg_we;
  logic [15:0] pg_wdata;

  // The index uses only the current context, so other contexts are unreachable.
  assign seg_idx = {state_reg.ctx, cpu_addr[`VA_SEG_HI:`VA_SEG_LO]};
  assign ste = seg_mem[seg_idx];
  assign ste_prot = ste[9:6];
  assign ste_ptr = ste[5:0];
  assign pg_idx = {ste_ptr, cpu_addr[`VA_PAGE_HI:`VA_PAGE_LO]};
  assign pte = page_mem[pg_idx];
  assign rights = prot_rights(ste_prot);
  assign lvl_rights = cpu_super ? rights[5:3] : rights[2:0];
  // Writes check w, fetches x, everything else r.
  assign allowed = cpu_write ? lvl_rights[1] : (cpu_fetch ? lvl_rights[0] : lvl_rights[2]);
  assign user_fault = !cpu_super && (cpu_addr >= `MMU_SYS_LIMIT);

  always_ff @(posedge clock) begin
    if (seg_we) begin
      seg_mem[seg_idx] <= seg_wdata;
    end
    if (pg_we) begin
      page_mem[pg_idx] <= pg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request handling.

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.berr = 1'b0;
    state_next.go = 1'b0;
    state_next.rdata = 16'h0000;
    seg_we = 1'b0;
    seg_wdata = {cpu_wdata[`STE_PROT_HI:`STE_PROT_LO], cpu_wdata[`STE_PTR_HI:`STE_PTR_LO]};
    pg_we = 1'b0;
    pg_wdata = cpu_wdata;
    if (cpu_req) begin
      state_next.done = 1'b1;
      if (user_fault) begin
        state_next.berr = 1'b1;
      end else begin
        case (cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO])
          WIN_PAGE: begin
            if (cpu_write) begin
              pg_we = 1'b1;
            end else begin
              state_next.rdata = pte;
            end
          end
          WIN_SEG: begin
            if (cpu_write) begin
              seg_we = 1'b1;
            end else begin
              state_next.rdata = {state_reg.ctx, ste_prot, 2'b00, ste_ptr};
            end
          end
          WIN_CTX: begin
            if (cpu_write) begin
              state_next.ctx = cpu_wdata[`CTX_DATA_HI:`CTX_DATA_LO];
            end
          end
          `MMU_MAPPED_WIN: begin
            // Every space goes through the same check; only the type differs.
            if (!allowed) begin
              state_next.berr = 1'b1;
            end else if (pte[`PTE_TYPE_HI:`PTE_TYPE_LO] == PG_NONE) begin
              state_next.berr = 1'b1;
            end else begin
              state_next.go = 1'b1;
              state_next.space = page_type_t'(pte[`PTE_TYPE_HI:`PTE_TYPE_LO]);
              state_next.maddr = {pte[`PTE_PPN_HI:`PTE_PPN_LO] & PPN_MASK,
                                  cpu_addr[`VA_BYTE_HI:0]};
              pg_we = 1'b1;
              pg_wdata = pte;
              pg_wdata[`PTE_ACCESSED] = 1'b1;
              pg_wdata[`PTE_MODIFIED] = pte[`PTE_MODIFIED] | cpu_write;
            end
          end
          default: begin
            // On-board devices and ROM are served elsewhere; this unit only answers.
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{ctx: `CTX_RESET, done: 1'b0, berr: 1'b0, rdata: 16'h0000,
                     go: 1'b0, maddr: 23'h000000, space: PG_ONBOARD};
    end else begin
      state_reg <= state_next;
    end
  end

  assign cpu_done = state_reg.done;
  assign cpu_berr = state_reg.berr;
  assign cpu_rdata = state_reg.rdata;
  assign mem_go = state_reg.go;
  assign mem_addr = state_reg.maddr;
  assign mem_space = state_reg.space;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic mapped_req;
  assign mapped_req = cpu_req && !user_fault && (cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO] == `MMU_MAPPED_WIN);

  property p_user_sys_fault;
    cpu_req && user_fault |=> cpu_berr && cpu_done && !mem_go;
  endproperty
  a_user_sys_fault: assert property (p_user_sys_fault) else $error("user system-space access not faulted");

  property p_ctx_load;
    cpu_req && cpu_super && cpu_write && cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO] == WIN_CTX
      |=> state_reg.ctx == $past(cpu_wdata[`CTX_DATA_HI:`CTX_DATA_LO]);
  endproperty
  a_ctx_load: assert property (p_ctx_load) else $error("context not loaded from data bits 15:12");

  property p_ctx_read;
    cpu_req && cpu_super && !cpu_write && cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO] == WIN_SEG
      |=> cpu_rdata[15:12] == $past(state_reg.ctx) && cpu_rdata[7:6] == 2'b00;
  endproperty
  a_ctx_read: assert property (p_ctx_read) else $error("segment read lacks current context");

  property p_prot_deny;
    mapped_req && !allowed |=> cpu_berr && !mem_go;
  endproperty
  a_prot_deny: assert property (p_prot_deny) else $error("denied access not faulted");

  property p_user_low_codes;
    mapped_req && !cpu_super && ste_prot <= 4'h5 |=> cpu_berr;
  endproperty
  a_user_low_codes: assert property (p_user_low_codes) else $error("user passed codes 0 to 5");

  property p_invalid_page;
    mapped_req && allowed && pte[`PTE_TYPE_HI:`PTE_TYPE_LO] == PG_NONE |=> cpu_berr && !mem_go;
  endproperty
  a_invalid_page: assert property (p_invalid_page) else $error("invalid page not faulted");

  property p_phys_addr;
    mapped_req && allowed && pte[`PTE_TYPE_HI:`PTE_TYPE_LO] != PG_NONE
      |=> mem_go && mem_addr == {$past(pte[11:0]) & PPN_MASK, $past(cpu_addr[10:0])}
          && mem_space == $past(pte[13:12]);
  endproperty
  a_phys_addr: assert property (p_phys_addr) else $error("wrong physical address or space");

  property p_stats_set;
    mapped_req && allowed && pte[13:12] != PG_NONE
      |=> page_mem[$past(pg_idx)][15] && page_mem[$past(pg_idx)][14] == ($past(pte[14]) | $past(cpu_write));
  endproperty
  a_stats_set: assert property (p_stats_set) else $error("page statistics not updated");

  property p_stats_hold;
    mapped_req && !allowed |=> page_mem[$past(pg_idx)][15:14] == $past(pte[15:14]);
  endproperty
  a_stats_hold: assert property (p_stats_hold) else $error("refused access changed statistics");

  property p_done_follows;
    cpu_req |=> cpu_done ##1 (cpu_done == $past(cpu_req));
  endproperty
  a_done_follows: assert property (p_done_follows) else $error("answer not one cycle after request");

  // Per-case restatements of the rights table for code 0, writes and user fetches, so a wrong grant there in prot_rights cannot hide behind allowed.
  property p_sup_code_zero;
    mapped_req && ste_prot == 4'h0 |=> cpu_berr && !mem_go;
  endproperty
  a_sup_code_zero: assert property (p_sup_code_zero) else $error("code 0 granted an access");

  property p_user_write_codes;
    mapped_req && !cpu_super && cpu_write && !(ste_prot inside {4'h8, 4'h9, 4'hB, 4'hF}) |=> cpu_berr;
  endproperty
  a_user_write_codes: assert property (p_user_write_codes) else $error("user write granted");

  property p_sup_write_codes;
    mapped_req && cpu_super && cpu_write
      && !(ste_prot inside {4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF}) |=> cpu_berr;
  endproperty
  a_sup_write_codes: assert property (p_sup_write_codes) else $error("supervisor write granted");

  property p_user_exec_codes;
    mapped_req && !cpu_super && !cpu_write && cpu_fetch && ste_prot < 4'hA |=> cpu_berr;
  endproperty
  a_user_exec_codes: assert property (p_user_exec_codes) else $error("user fetch granted");

  property p_ppn_ignored;
    mem_go |-> (mem_addr[22:11] & ~PPN_MASK) == 12'h000;
  endproperty
  a_ppn_ignored: assert property (p_ppn_ignored) else $error("undecoded page number bits passed");

  property p_invalid_stats;
    mapped_req && pte[`PTE_TYPE_HI:`PTE_TYPE_LO] == PG_NONE
      |=> page_mem[$past(pg_idx)][15:14] == $past(pte[15:14]);
  endproperty
  a_invalid_stats: assert property (p_invalid_stats) else $error("invalid page changed statistics");

  property p_ctx_hold;
    !(cpu_req && cpu_super && cpu_write && cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO] == WIN_CTX)
      |=> $stable(state_reg.ctx);
  endproperty
  a_ctx_hold: assert property (p_ctx_hold) else $error("context changed without a context write");

  property p_seg_write;
    cpu_req && cpu_super && cpu_write && cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO] == WIN_SEG
      |=> seg_mem[$past(seg_idx)] == {$past(cpu_wdata[11:8]), $past(cpu_wdata[5:0])};
  endproperty
  a_seg_write: assert property (p_seg_write) else $error("segment entry not stored");

  property p_page_write;
    cpu_req && cpu_super && cpu_write && cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO] == WIN_PAGE
      |=> page_mem[$past(pg_idx)] == $past(cpu_wdata);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page entry not stored");

  property p_window_quiet;
    cpu_req && cpu_super && cpu_addr[`MMU_WIN_HI:`MMU_WIN_LO] inside {3'h1, 3'h2, 3'h3, 3'h4}
      |=> cpu_done && !cpu_berr && !mem_go && cpu_rdata == 16'h0000;
  endproperty
  a_window_quiet: assert property (p_window_quiet) else $error("device window access misanswered");

  property p_mapped_rdata;
    mapped_req |=> cpu_rdata == 16'h0000;
  endproperty
  a_mapped_rdata: assert property (p_mapped_rdata) else $error("mapped access returned data");

  c_granted_write: cover property (mapped_req && allowed && cpu_write ##1 mem_go);
  c_user_fault: cover property (cpu_req && user_fault ##1 cpu_berr);
  c_ctx_switch: cover property (cpu_req && cpu_write && cpu_addr[23:21] == WIN_CTX ##1 cpu_req);
  c_busio: cover property (mem_go && mem_space == PG_BUSIO);

endmodule // segment_page_mmu
`default_nettype wire
